// [design/fault_status_pkg.sv]
/*
 * Constants for the fault status register bank: register offsets, field
 * positions, reset values and the synchroniser depth.
 * Assumes it is compiled before every design file that names it.
 */
package fault_status_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  THERMAL_FAULT_STATUS_ADDR      = 8'h04;
  localparam logic [7:0]  SUPPLY_FAULT_STATUS_ADDR       = 8'h05;
  localparam logic [7:0]  DRIVER_OVERCURRENT_STATUS_ADDR = 8'h06;
  localparam logic [15:0] STATUS_RESET                   = 16'h0000;
  localparam logic [15:0] READ_ZERO                      = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PARITY_BIT                = 15;
  localparam int FET_OVERTEMP_WARNING_BIT  = 1;
  localparam int FET_OVERTEMP_SHUTDOWN_BIT = 0;
  localparam int SUPPLY_LOW_WARNING_BIT    = 7;
  localparam int SUPPLY_OVER_VOLTAGE_BIT   = 6;
  localparam int PUMP_UNDER_VOLTAGE_BIT    = 4;
  localparam int SUPPLY_UNDER_VOLTAGE_BIT  = 1;
  localparam int PHASE_C_HIGH_BIT          = 6;
  localparam int PHASE_B_HIGH_BIT          = 5;
  localparam int PHASE_A_HIGH_BIT          = 4;
  localparam int PHASE_C_LOW_BIT           = 2;
  localparam int PHASE_B_LOW_BIT           = 1;
  localparam int PHASE_A_LOW_BIT           = 0;

  // ****************************************************************
  // Flag vector layout and sync depth
  // ****************************************************************
  localparam int NUM_FLAGS   = 12;
  localparam int SYNC_STAGES = 3;
  localparam logic FLAG_RESET = 1'b0;

endpackage

// [design/fault_flag.sv]
/*
 * One sticky fault flag with its own three-stage input synchroniser.
 * Assumes the raw detector level is asynchronous to sys_clk and that the
 * clear and auto-clear enables come from sys_clk logic.
 */
`timescale 1ns/1ps
module fault_flag (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic fault_raw,
  input  wire logic auto_clear_en,
  input  wire logic clear,
  output logic      flag_ff
);

  logic [fault_status_pkg::SYNC_STAGES-1:0] sync_ff;
  logic [fault_status_pkg::SYNC_STAGES-1:0] nxt_sync;
  logic                                     level_ff;
  logic                                     nxt_level;
  logic                                     nxt_flag;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_sync  = {sync_ff[fault_status_pkg::SYNC_STAGES-2:0], fault_raw};
    // Only the last two stages are compared; the first stage is left
    // alone so that metastability cannot reach the flag.
    nxt_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;
    // A fault present in the clear cycle keeps the flag set.
    nxt_flag  = level_ff | (flag_ff & ~clear & ~(auto_clear_en & ~level_ff));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_ff  <= '0;
      level_ff <= fault_status_pkg::FLAG_RESET;
      flag_ff  <= fault_status_pkg::FLAG_RESET;
    end else if (ce) begin
      sync_ff  <= nxt_sync;
      level_ff <= nxt_level;
      flag_ff  <= nxt_flag;
    end
  end

endmodule // fault_flag

// [design/fault_status_registers.sv]
/*
 * Read-only fault status register bank of a three-phase motor driver:
 * thermal, supply and per-phase overcurrent flags with parity on read.
 * Assumes the fault detectors and the sleep pin are asynchronous, and that
 * the fault-clear command and the retry enables come from sys_clk logic.
 */
// How it works
// R01: Bit 15 returns parity when enabled.
// R02: FET warning at bit 1, retry auto-clears.
// R03: FET shutdown at bit 0, retry auto-clears.
// R04: Supply low warning bit 7 stays latched.
// R05: Over-voltage bit 6 stays latched.
// R06: Pump under-voltage bit 4 stays latched.
// R07: Supply under-voltage bit 1 stays latched.
// R08: Overcurrent flags high 6..4, low 2..0.
// R09: Overcurrent flags auto-clear under retry.
// R10: Writes ignored; reserved bits read zero.
`timescale 1ns/1ps
module fault_status_registers (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        sleep_bar_pin,
  input  wire logic        fault_clear_cmd,
  input  wire logic        spi_parity_enable,
  input  wire logic        thermal_retry_en,
  input  wire logic        overcurrent_retry_en,
  input  wire logic        fet_overtemp_warning_det,
  input  wire logic        fet_overtemp_shutdown_det,
  input  wire logic        supply_low_warning_det,
  input  wire logic        supply_over_voltage_det,
  input  wire logic        pump_under_voltage_det,
  input  wire logic        supply_under_voltage_det,
  input  wire logic [2:0]  high_overcurrent_det,
  input  wire logic [2:0]  low_overcurrent_det,
  input  wire logic        rd_en,
  input  wire logic [7:0]  rd_addr,
  output logic      [15:0] rd_data_ff
);

  logic [2:0]                                sleep_sync_ff;
  logic [2:0]                                nxt_sleep_sync;
  logic                                      sleep_level_ff;
  logic                                      nxt_sleep_level;
  logic                                      clear_all;
  logic [fault_status_pkg::NUM_FLAGS-1:0]    flags;
  logic [15:0]                               thermal_word;
  logic [15:0]                               supply_word;
  logic [15:0]                               driver_word;
  logic [15:0]                               sel_word;
  logic [15:0]                               nxt_rd_data;

  // ****************************************************************
  // Sleep pin synchroniser and common clear
  // ****************************************************************
  always_comb begin
    nxt_sleep_sync  = {sleep_sync_ff[1:0], sleep_bar_pin};
    nxt_sleep_level = (sleep_sync_ff[1] == sleep_sync_ff[2]) ? sleep_sync_ff[2]
                                                              : sleep_level_ff;
    // Flags with no fault present stay cleared for as long as the sleep pin is held low.
    clear_all       = fault_clear_cmd | ~sleep_level_ff;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sleep_sync_ff  <= 3'h7;
      sleep_level_ff <= 1'b1;
    end else if (ce) begin
      sleep_sync_ff  <= nxt_sleep_sync;
      sleep_level_ff <= nxt_sleep_level;
    end
  end

  // ****************************************************************
  // Thermal flags
  // ****************************************************************
  // Flag order in the vector: 0 warn, 1 shutdown, 2 low warn, 3 ov, 4 pump uv,
  // 5 supply uv, 6..8 high side A..C, 9..11 low side A..C.
  fault_flag fet_overtemp_warning_u ( // [R02]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (fet_overtemp_warning_det),
    .auto_clear_en (thermal_retry_en),
    .clear         (clear_all),
    .flag_ff       (flags[0])
  );

  fault_flag fet_overtemp_shutdown_u ( // [R03]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (fet_overtemp_shutdown_det),
    .auto_clear_en (thermal_retry_en),
    .clear         (clear_all),
    .flag_ff       (flags[1])
  );

  // ****************************************************************
  // Supply flags
  // ****************************************************************
  // Supply flags never auto-clear, whatever their retry setting, so the
  // host always sees a supply event until it clears it on purpose.
  fault_flag supply_low_warning_u ( // [R04]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (supply_low_warning_det),
    .auto_clear_en (1'b0),
    .clear         (clear_all),
    .flag_ff       (flags[2])
  );

  fault_flag supply_over_voltage_u ( // [R05]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (supply_over_voltage_det),
    .auto_clear_en (1'b0),
    .clear         (clear_all),
    .flag_ff       (flags[3])
  );

  fault_flag pump_under_voltage_u ( // [R06]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (pump_under_voltage_det),
    .auto_clear_en (1'b0),
    .clear         (clear_all),
    .flag_ff       (flags[4])
  );

  fault_flag supply_under_voltage_u ( // [R07]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (supply_under_voltage_det),
    .auto_clear_en (1'b0),
    .clear         (clear_all),
    .flag_ff       (flags[5])
  );

  // ****************************************************************
  // Overcurrent flags
  // ****************************************************************
  // Bit 0 of each detector bus is phase A, bit 2 is phase C.
  fault_flag phase_a_high_u ( // [R08] [R09]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (high_overcurrent_det[0]),
    .auto_clear_en (overcurrent_retry_en),
    .clear         (clear_all),
    .flag_ff       (flags[6])
  );

  fault_flag phase_b_high_u ( // [R08] [R09]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (high_overcurrent_det[1]),
    .auto_clear_en (overcurrent_retry_en),
    .clear         (clear_all),
    .flag_ff       (flags[7])
  );

  fault_flag phase_c_high_u ( // [R08] [R09]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (high_overcurrent_det[2]),
    .auto_clear_en (overcurrent_retry_en),
    .clear         (clear_all),
    .flag_ff       (flags[8])
  );

  fault_flag phase_a_low_u ( // [R08] [R09]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (low_overcurrent_det[0]),
    .auto_clear_en (overcurrent_retry_en),
    .clear         (clear_all),
    .flag_ff       (flags[9])
  );

  fault_flag phase_b_low_u ( // [R08] [R09]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (low_overcurrent_det[1]),
    .auto_clear_en (overcurrent_retry_en),
    .clear         (clear_all),
    .flag_ff       (flags[10])
  );

  fault_flag phase_c_low_u ( // [R08] [R09]
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .fault_raw     (low_overcurrent_det[2]),
    .auto_clear_en (overcurrent_retry_en),
    .clear         (clear_all),
    .flag_ff       (flags[11])
  );

  // ****************************************************************
  // Register words and read port
  // ****************************************************************
  always_comb begin
    thermal_word = fault_status_pkg::READ_ZERO;                    // [R10]
    thermal_word[fault_status_pkg::FET_OVERTEMP_WARNING_BIT]  = flags[0]; // [R02]
    thermal_word[fault_status_pkg::FET_OVERTEMP_SHUTDOWN_BIT] = flags[1]; // [R03]
    supply_word = fault_status_pkg::READ_ZERO;
    supply_word[fault_status_pkg::SUPPLY_LOW_WARNING_BIT]   = flags[2];  // [R04]
    supply_word[fault_status_pkg::SUPPLY_OVER_VOLTAGE_BIT]  = flags[3];  // [R05]
    supply_word[fault_status_pkg::PUMP_UNDER_VOLTAGE_BIT]   = flags[4];  // [R06]
    supply_word[fault_status_pkg::SUPPLY_UNDER_VOLTAGE_BIT] = flags[5];  // [R07]
    driver_word = fault_status_pkg::READ_ZERO;
    driver_word[fault_status_pkg::PHASE_A_HIGH_BIT] = flags[6];          // [R08]
    driver_word[fault_status_pkg::PHASE_B_HIGH_BIT] = flags[7];          // [R08]
    driver_word[fault_status_pkg::PHASE_C_HIGH_BIT] = flags[8];          // [R08]
    driver_word[fault_status_pkg::PHASE_A_LOW_BIT]  = flags[9];          // [R08]
    driver_word[fault_status_pkg::PHASE_B_LOW_BIT]  = flags[10];         // [R08]
    driver_word[fault_status_pkg::PHASE_C_LOW_BIT]  = flags[11];         // [R08]
    unique case (rd_addr)
      fault_status_pkg::THERMAL_FAULT_STATUS_ADDR:      sel_word = thermal_word;
      fault_status_pkg::SUPPLY_FAULT_STATUS_ADDR:       sel_word = supply_word;
      fault_status_pkg::DRIVER_OVERCURRENT_STATUS_ADDR: sel_word = driver_word;
      default:                                          sel_word = fault_status_pkg::READ_ZERO;
    endcase
    // Even parity over the whole word; bit 15 is zero otherwise. [R01]
    sel_word[fault_status_pkg::PARITY_BIT] = spi_parity_enable & (^sel_word[14:0]);
    nxt_rd_data = rd_en ? sel_word : rd_data_ff;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= fault_status_pkg::STATUS_RESET;
    end else if (ce) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

endmodule // fault_status_registers

// [verification/fault_status_monitor.sv]
/* Checker for the status bank read port and supply latches.
   Assumes it sees only ports of the top module. */
`timescale 1ns/1ps
module fault_status_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        sleep_bar_pin,
  input wire logic        fault_clear_cmd,
  input wire logic        spi_parity_enable,
  input wire logic        fet_overtemp_warning_det,
  input wire logic        fet_overtemp_shutdown_det,
  input wire logic        rd_en,
  input wire logic [7:0]  rd_addr,
  input wire logic [15:0] rd_data_ff
);
  // ****
  // Properties
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire take = ce && rd_en;
  sequence s_rd5; take && rd_addr == 8'h05; endsequence
  // Eight quiet cycles let a sleep clear drain out of the synchroniser.
  sequence s_calm; (ce && sleep_bar_pin && !fault_clear_cmd) [*8]; endsequence
  // A sleep pin held low for eight cycles with both thermal detectors quiet has cleared both thermal flags.
  sequence s_asleep;
    (ce && !sleep_bar_pin && !fet_overtemp_warning_det && !fet_overtemp_shutdown_det) [*8];
  endsequence
  property p_unmapped;
    take && (rd_addr < 8'h04 || rd_addr > 8'h06) |=> rd_data_ff == 16'h0;
  endproperty
  property p_parity; take && spi_parity_enable |=> rd_data_ff[15] == ^rd_data_ff[14:0]; endproperty
  property p_rsv_thermal; take && rd_addr == 8'h04 |=> rd_data_ff[14:2] == 13'h0; endproperty
  property p_rsv_supply; s_rd5 |=> (rd_data_ff & 16'h7f2d) == 16'h0; endproperty
  property p_rsv_driver; take && rd_addr == 8'h06 |=> (rd_data_ff & 16'h7f88) == 16'h0; endproperty
  property p_hold; !take |=> $stable(rd_data_ff); endproperty
  property p_latch;
    s_calm ##0 s_rd5 ##1 s_rd5 |=> ($past(rd_data_ff) & ~rd_data_ff & 16'h00d2) == 16'h0;
  endproperty
  property p_sleep_data;
    s_asleep ##0 (take && rd_addr == 8'h04) |=> rd_data_ff[1:0] == 2'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_parity: assert property (p_parity) else $error("parity bit wrong");
  a_rsv_thermal: assert property (p_rsv_thermal) else $error("thermal reserved set");
  a_rsv_supply: assert property (p_rsv_supply) else $error("supply reserved set");
  a_rsv_driver: assert property (p_rsv_driver) else $error("driver reserved set");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_latch: assert property (p_latch) else $error("supply flag fell");
  a_sleep_data: assert property (p_sleep_data) else $error("thermal flag kept in sleep");
endmodule // fault_status_monitor
bind fault_status_registers fault_status_monitor mon_u (.sys_clk(sys_clk), .rst(rst), .ce(ce),
  .sleep_bar_pin(sleep_bar_pin), .fault_clear_cmd(fault_clear_cmd), .rd_en(rd_en),
  .spi_parity_enable(spi_parity_enable), .rd_addr(rd_addr), .rd_data_ff(rd_data_ff),
  .fet_overtemp_warning_det(fet_overtemp_warning_det),
  .fet_overtemp_shutdown_det(fet_overtemp_shutdown_det));

// [verification/status_host.sv]
/* Host model that reads the status bank.
   Assumes it is called at a falling edge of sys_clk. */
`timescale 1ns/1ps
module status_host (
  input  wire logic        sys_clk,
  input  wire logic [15:0] rd_data_ff,
  output logic             rd_en,
  output logic      [7:0]  rd_addr
);
  initial {rd_en, rd_addr} = 9'h000;
  // The strobe stays up between calls so reads can run back to back.
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge sys_clk);
    d = rd_data_ff;
  endtask
  // A released address is inverted so a stale value never looks valid.
  task automatic idle();
    rd_en = 1'b0;
    rd_addr = ~rd_addr;
  endtask
endmodule // status_host

// [verification/fault_status_registers_bench.sv]
/* Self-checking bench for the fault status bank.
   Assumes read data is sampled half a cycle after the taking edge. */
`timescale 1ns/1ps
module fault_status_registers_bench;
  logic        sys_clk = 1'b0, rst = 1'b1, slp = 1'b1, clr = 1'b0, pen = 1'b1;
  logic        tre = 1'b1, ore = 1'b1, ce = 1'b1, rd_en;
  logic [11:0] det = 12'h000;
  logic [7:0]  rd_addr;
  logic [15:0] rd_data_ff;
  int          failures = 0, comparisons = 0;
  always #2 sys_clk = ~sys_clk;
  fault_status_registers dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce), .sleep_bar_pin(slp),
    .fault_clear_cmd(clr), .spi_parity_enable(pen), .thermal_retry_en(tre),
    .overcurrent_retry_en(ore), .fet_overtemp_warning_det(det[11]),
    .fet_overtemp_shutdown_det(det[10]), .supply_low_warning_det(det[9]),
    .supply_over_voltage_det(det[8]), .pump_under_voltage_det(det[7]),
    .supply_under_voltage_det(det[6]), .high_overcurrent_det(det[5:3]),
    .low_overcurrent_det(det[2:0]), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_ff(rd_data_ff));
  status_host host_u (.sys_clk(sys_clk), .rd_data_ff(rd_data_ff), .rd_en(rd_en),
    .rd_addr(rd_addr));
  function automatic logic [15:0] p(input logic [15:0] x);
    return {pen & ^x[14:0], x[14:0]};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    host_u.read(a, d);
    comparisons++;
    if (d !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, d, e);
    end
  endtask
  // Supply is read twice in a row so the latch check sees a pair.
  task automatic bank(input logic [15:0] t, input logic [15:0] s, input logic [15:0] o);
    chk(8'h04, p(t));
    chk(8'h05, p(s));
    chk(8'h05, p(s));
    chk(8'h06, p(o));
    host_u.idle();
    wt(1);
  endtask
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    wt(3000);
    failures++;
    stop_test();
  end
  initial begin
    wt(5);
    rst = 1'b0;
    chk(8'h07, 16'h0000);
    chk(8'h00, 16'h0000);
    bank(16'h0000, 16'h0000, 16'h0000);
    $display("test reset done");
    det = 12'hfea;
    wt(8);
    bank(16'h0003, 16'h00d2, 16'h0052);
    det = 12'h000;
    wt(8);
    bank(16'h0000, 16'h00d2, 16'h0000);
    $display("test retry done");
    {tre, ore} = 2'b00;
    det = 12'hfea;
    wt(8);
    det = 12'h000;
    wt(8);
    bank(16'h0003, 16'h00d2, 16'h0052);
    clr = 1'b1;
    wt(1);
    clr = 1'b0;
    wt(2);
    bank(16'h0000, 16'h0000, 16'h0000);
    det = 12'hfea;
    wt(8);
    det = 12'h000;
    slp = 1'b0;
    wt(8);
    chk(8'h04, 16'h0000);
    slp = 1'b1;
    wt(8);
    bank(16'h0000, 16'h0000, 16'h0000);
    $display("test clear done");
    pen = 1'b0;
    det = 12'hfea;
    wt(8);
    bank(16'h0003, 16'h00d2, 16'h0052);
    $display("test parity done");
    ce = 1'b0;
    chk(8'h04, 16'h0052);
    ce = 1'b1;
    chk(8'h04, 16'h0003);
    $display("test enable done");
    stop_test();
  end
endmodule // fault_status_registers_bench
